// *** hostport_pkg.sv ***
/*
 * Constants shared by the parallel host port and its write buffer.
 * Assumes a single 200 MHz clock, MCLK.
 */
package hostport_pkg;
   localparam int          DATA_W       = 8;                 // Host data bus width
   localparam int          ADDR_W       = 8;                 // Pointer width
   localparam int          FIFO_DEPTH   = 8;                 // DMA write buffer depth
   localparam int          CLK_MHZ      = 200;               // Local clock rate
   localparam int          REF_MHZ      = 48;                // Nominal device reference clock rate
   localparam int          RST_REF_CLKS = 16;                // Startup interval in reference clocks
   // Startup interval at the local rate, rounded up to whole cycles
   localparam int          STARTUP_CYC  = (RST_REF_CLKS * CLK_MHZ + REF_MHZ - 1) / REF_MHZ;
   localparam int          CNT_W        = 8;                 // Startup counter width
   localparam logic [7:0]  PTR_RESET    = 8'h00;             // Pointer value after reset
   localparam int          SYNC_W       = 7;                 // Synchronised control lines
   // Bit positions of the synchronised control vector
   localparam int          B_CS         = 0;
   localparam int          B_RD         = 1;
   localparam int          B_WR         = 2;
   localparam int          B_AS         = 3;
   localparam int          B_ALE        = 4;
   localparam int          B_ACK        = 5;
   localparam int          B_RST        = 6;
endpackage

// *** wr_fifo.sv ***
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/100ps
module wr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wptr_r;
   logic [AW-1:0]    rptr_r;
   logic [AW:0]      count_r;
   logic             push;
   logic             pop;

   // Honest full and empty from the occupancy count
   assign in_ready  = (count_r != (AW+1)'(DEPTH));
   assign out_valid = (count_r != '0);
   assign out_data  = mem_r[rptr_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Pointer wrap
   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH-1)) ? '0 : AW'(p + 1'b1);
   endfunction

   // Storage
   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wptr_r] <= in_data;
      end
   end

   // Pointers and count
   always_ff @(posedge clk) begin
      if (rst) begin
         wptr_r  <= '0;
         rptr_r  <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wptr_r <= bump(wptr_r);
         end
         if (pop) begin
            rptr_r <= bump(rptr_r);
         end
         if (push && !pop) begin
            count_r <= (AW+1)'(count_r + 1'b1);
         end else if (pop && !push) begin
            count_r <= (AW+1)'(count_r - 1'b1);
         end
      end
   end
endmodule

// *** byte_host_port.sv ***
/*
 * Byte-wide host port: address pointer, programmed reads and writes,
 * and a write-only DMA handshake into an eight-word buffer.
 * Assumes host pins arrive asynchronously to MCLK; the internal side
 * offers a pointer/data request port and drains the DMA buffer.
 */
`timescale 1ns/100ps
module byte_host_port
   import hostport_pkg::*;
#(
   parameter int DEPTH = hostport_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic                         MCLK,
   input  wire logic                         RESET,
   // Host bus pins
   input  wire logic                         CHIP_SEL_N,
   input  wire logic                         READ_STROBE_N,
   input  wire logic                         WRITE_STROBE_N,
   input  wire logic                         ADDR_SELECT,
   input  wire logic                         ALE,
   input  wire logic                         DEVICE_RESET_N,
   input  wire logic [hostport_pkg::DATA_W-1:0] DATA_IN,
   output logic [hostport_pkg::DATA_W-1:0]   DATA_OUT,
   output logic                              DATA_OE,
   // DMA pins
   input  wire logic                         DMA_ACK_N,
   output logic                              DMA_REQ_N,
   // Internal access port
   input  wire logic                         DMA_ENABLE,
   output logic [hostport_pkg::ADDR_W-1:0]   PTR,
   output logic                              REG_WR,
   output logic                              REG_RD,
   output logic [hostport_pkg::DATA_W-1:0]   REG_WDATA,
   input  wire logic [hostport_pkg::DATA_W-1:0] REG_RDATA,
   // DMA buffer drain
   output logic                              DMA_VALID,
   input  wire logic                         DMA_READY,
   output logic [hostport_pkg::DATA_W-1:0]   DMA_DATA,
   // Status
   output logic                              PORT_READY
);
   import hostport_pkg::*;

   typedef enum logic [3:0] {
      D_IDLE = 4'b0001,
      D_REQ  = 4'b0010,
      D_ACK  = 4'b0100,
      D_BAD  = 4'b1000
   } dma_state_t;

   logic [SYNC_W-1:0] sync1_r;
   logic [SYNC_W-1:0] sync2_r;
   logic [SYNC_W-1:0] prev_r;
   logic [DATA_W-1:0] din1_r;
   logic [DATA_W-1:0] din2_r;
   logic              cs;
   logic              rd;
   logic              wr;
   logic              as_hi;
   logic              ale;
   logic              ack;
   logic              rst_pin;
   logic              wr_rise;
   logic              rd_fall;
   logic              rd_rise;
   logic              wr_fall;
   logic              ack_fall;
   logic              ack_rise;
   logic              soft_rst;
   logic [CNT_W-1:0]  start_cnt_r;
   logic [ADDR_W-1:0] ptr_r;
   logic              reg_wr_r;
   logic              reg_rd_r;
   logic [DATA_W-1:0] wdata_r;
   logic [DATA_W-1:0] dout_r;
   logic              oe_r;
   dma_state_t        dstate_r;
   logic              req_n_r;
   logic              wr_seen_r;
   logic              fifo_push;
   logic              fifo_ready;

   //////////////////////////////////////////////////////////////////////
   // Pin synchronisers; the first stage is read only by the second
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         sync1_r <= 7'h7f;
         sync2_r <= 7'h7f;
         prev_r  <= 7'h7f;
         din1_r  <= 8'h00;
         din2_r  <= 8'h00;
      end else begin
         sync1_r <= {DEVICE_RESET_N, DMA_ACK_N, ~ALE, ADDR_SELECT, WRITE_STROBE_N, READ_STROBE_N, CHIP_SEL_N};
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
         din1_r  <= DATA_IN;
         din2_r  <= din1_r;
      end
   end

   // Active-high views and edges of the synchronised lines
   assign cs       = ~sync2_r[B_CS];
   assign rd       = ~sync2_r[B_RD];
   assign wr       = ~sync2_r[B_WR];
   assign as_hi    = sync2_r[B_AS];
   assign ale      = ~sync2_r[B_ALE];
   assign ack      = ~sync2_r[B_ACK];
   assign rst_pin  = ~sync2_r[B_RST];
   assign wr_rise  = ~prev_r[B_WR] & sync2_r[B_WR];
   assign wr_fall  = prev_r[B_WR] & ~sync2_r[B_WR];
   assign rd_fall  = prev_r[B_RD] & ~sync2_r[B_RD];
   assign rd_rise  = ~prev_r[B_RD] & sync2_r[B_RD];
   assign ack_fall = prev_r[B_ACK] & ~sync2_r[B_ACK];
   assign ack_rise = ~prev_r[B_ACK] & sync2_r[B_ACK];
   assign soft_rst = RESET | rst_pin;

   //////////////////////////////////////////////////////////////////////
   // Startup interval after the pin reset, scaled to the local clock
   always_ff @(posedge MCLK) begin
      if (soft_rst) begin
         start_cnt_r <= '0;
      end else if (start_cnt_r != CNT_W'(STARTUP_CYC)) begin
         start_cnt_r <= CNT_W'(start_cnt_r + 1'b1);
      end
   end

   // Port ready flag
   always_ff @(posedge MCLK) begin
      if (soft_rst) begin
         PORT_READY <= 1'b0;
      end else begin
         PORT_READY <= (start_cnt_r == CNT_W'(STARTUP_CYC));
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Address pointer: select-low write or latch strobe loads it
   always_ff @(posedge MCLK) begin
      if (soft_rst) begin
         ptr_r <= PTR_RESET;
      end else if (ale) begin
         ptr_r <= din2_r;
      end else if (cs && !ack && wr_rise && !as_hi) begin
         ptr_r <= din2_r;
      end
   end

   // Data strobes toward the internal registers and memory
   always_ff @(posedge MCLK) begin
      if (soft_rst) begin
         reg_wr_r <= 1'b0;
         reg_rd_r <= 1'b0;
         wdata_r  <= 8'h00;
      end else begin
         reg_wr_r <= cs && !ack && wr_rise && as_hi && !ale;
         reg_rd_r <= cs && !ack && rd_fall && as_hi && !ale;
         if (cs && !ack && wr_rise && as_hi) begin
            wdata_r <= din2_r;
         end
      end
   end

   // Read data drive: enabled while a selected read strobe is low
   always_ff @(posedge MCLK) begin
      if (soft_rst) begin
         dout_r <= 8'h00;
         oe_r   <= 1'b0;
      end else begin
         if (reg_rd_r) begin
            dout_r <= REG_RDATA;
         end
         oe_r <= cs && rd && as_hi && !ack && !rd_rise;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // DMA handshake: request, acknowledge then write strobe
   always_ff @(posedge MCLK) begin
      if (soft_rst) begin
         dstate_r  <= D_IDLE;
         req_n_r   <= 1'b1;
         wr_seen_r <= 1'b0;
      end else begin
         case (dstate_r)
            D_IDLE: begin
               wr_seen_r <= 1'b0;
               if (DMA_ENABLE && fifo_ready && PORT_READY && !ack) begin
                  req_n_r  <= 1'b0;
                  dstate_r <= D_REQ;
               end
            end
            D_REQ: begin
               if (ack_fall && !wr) begin
                  dstate_r <= D_ACK;
               end else if (wr && !ack) begin
                  dstate_r <= D_BAD;
               end
            end
            D_ACK: begin
               if (wr_fall) begin
                  req_n_r   <= 1'b1;
                  wr_seen_r <= 1'b1;
               end
               // Acknowledge released with no write strobe: keep the request, refuse new ones
               if (ack_rise && (wr_seen_r || wr_fall)) begin
                  dstate_r <= D_IDLE;
                  req_n_r  <= 1'b1;
               end else if (ack_rise) begin
                  dstate_r <= D_BAD;
               end
            end
            D_BAD: begin
               // Out-of-order strobes: no further request until DMA is re-enabled
               req_n_r <= 1'b0;
               if (!DMA_ENABLE) begin
                  req_n_r  <= 1'b1;
                  dstate_r <= D_IDLE;
               end
            end
            default: begin
               dstate_r <= D_IDLE;
               req_n_r  <= 1'b1;
            end
         endcase
      end
   end

   // DMA byte is taken on the write strobe rise under acknowledge only
   assign fifo_push = (dstate_r == D_ACK) && ack && wr_rise && !cs;

   wr_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk       (MCLK),
      .rst       (soft_rst),
      .in_valid  (fifo_push),
      .in_ready  (fifo_ready),
      .in_data   (din2_r),
      .out_valid (DMA_VALID),
      .out_ready (DMA_READY),
      .out_data  (DMA_DATA)
   );

   //////////////////////////////////////////////////////////////////////
   // Outputs
   assign PTR       = ptr_r;
   assign REG_WR    = reg_wr_r;
   assign REG_RD    = reg_rd_r;
   assign REG_WDATA = wdata_r;
   assign DATA_OUT  = dout_r;
   assign DATA_OE   = oe_r;
   assign DMA_REQ_N = req_n_r;
endmodule

// *** byte_host_port_sva.sv ***
/* Checker for the host port: strobe decoding, pointer source, DMA
   handshake, buffer drain and start-up. Bound to byte_host_port. */
`timescale 1ns/100ps
module byte_host_port_sva
   import hostport_pkg::*;
(
   // Clock and resets
   input wire logic                            MCLK,
   input wire logic                            RESET,
   input wire logic                            DEVICE_RESET_N,
   // Host bus
   input wire logic                            CHIP_SEL_N,
   input wire logic                            READ_STROBE_N,
   input wire logic                            WRITE_STROBE_N,
   input wire logic                            ADDR_SELECT,
   input wire logic                            ALE,
   input wire logic                            DMA_ACK_N,
   input wire logic                            DMA_REQ_N,
   // Internal side
   input wire logic                            DMA_ENABLE,
   input wire logic [hostport_pkg::ADDR_W-1:0] PTR,
   input wire logic                            REG_WR,
   input wire logic                            REG_RD,
   input wire logic                            DMA_VALID,
   input wire logic                            DMA_READY,
   input wire logic [hostport_pkg::DATA_W-1:0] DMA_DATA,
   input wire logic                            PORT_READY
);
   int cnt_r;

   ////////////////////////////////////////////////////////////
   // Cycles since the last reset, saturating
   always_ff @(posedge MCLK) begin
      if (RESET || !DEVICE_RESET_N) cnt_r <= 0;
      else if (cnt_r < 255) cnt_r <= cnt_r + 1;
   end

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RESET);

   // Acknowledge low, then the write strobe falls
   sequence s_ack_wr;
      !DMA_ACK_N ##1 (!DMA_ACK_N && $fell(WRITE_STROBE_N));
   endsequence

   ////////////////////////////////////////////////////////////
   AST_RESET: assert property (disable iff (1'b0) RESET |=> DMA_REQ_N && !REG_WR && PTR == PTR_RESET)
      else $error("Outputs not at rest after reset");
   AST_WR_SEL: assert property (REG_WR |-> !$past(CHIP_SEL_N, 4) && $past(WRITE_STROBE_N, 3))
      else $error("Register write without selected write strobe");
   AST_WR_PULSE: assert property (REG_WR |=> !REG_WR)
      else $error("Register write longer than one cycle");
   AST_RD_SEL: assert property (REG_RD |-> !$past(CHIP_SEL_N, 3) && !$past(READ_STROBE_N, 3) && $past(ADDR_SELECT, 3))
      else $error("Register read without selected data read");
   AST_PTR_SRC: assert property ($changed(PTR) |-> $past(ALE, 3) || $past(ALE, 4) || !$past(ADDR_SELECT, 4)
                                 || !$past(DEVICE_RESET_N, 3))
      else $error("Pointer changed without a pointer load");
   AST_REQ_START: assert property ($fell(DMA_REQ_N) |-> PORT_READY && $past(DMA_ENABLE))
      else $error("Request raised while not allowed");
   AST_REQ_WAIT: assert property (!DMA_REQ_N && DMA_ACK_N && DMA_ENABLE |=> !DMA_REQ_N)
      else $error("Request withdrawn before acknowledge");
   AST_REQ_CLEAR: assert property (s_ack_wr ##0 (!DMA_REQ_N && DMA_ENABLE) |-> ##[2:6] DMA_REQ_N)
      else $error("Request not cleared after ordered strobes");
   AST_DRAIN_HOLD: assert property (DMA_VALID && !DMA_READY |=> DMA_VALID && $stable(DMA_DATA))
      else $error("Buffer output changed while stalled");
   AST_STARTUP: assert property ($rose(PORT_READY) |-> cnt_r >= STARTUP_CYC - 2 && cnt_r <= STARTUP_CYC + 3)
      else $error("Start-up interval has the wrong length");
endmodule

bind byte_host_port byte_host_port_sva u_sva (.*);

// *** host_bus_model.sv ***
/* Processor bus and DMA controller facing the host port.
   Driven through its tasks by the testbench; one clock, MCLK. */
`timescale 1ns/100ps
module host_bus_model (
   // Clock
   input wire logic        MCLK,
   // Host bus pins
   output logic            CHIP_SEL_N,
   output logic            READ_STROBE_N,
   output logic            WRITE_STROBE_N,
   output logic            ADDR_SELECT,
   output logic            ALE,
   output logic [7:0]      DATA_IN,
   input wire logic [7:0]  DATA_OUT,
   input wire logic        DATA_OE,
   // DMA pins
   output logic            DMA_ACK_N
);
   // Idle bus: select high, latch strobe low
   initial begin
      {CHIP_SEL_N, READ_STROBE_N, WRITE_STROBE_N, DMA_ACK_N} = 4'hf;
      ADDR_SELECT = 1'b1;
      ALE = 1'b0;
      DATA_IN = 8'h00;
   end

   ////////////////////////////////////////////////////////////
   // Programmed access; read data is x unless the port drives
   task automatic acc(input logic cs_n, rd, as, input logic [7:0] d, output logic [7:0] q);
      @(posedge MCLK);
      CHIP_SEL_N <= cs_n;
      ADDR_SELECT <= as;
      DATA_IN <= d;
      @(posedge MCLK);
      if (rd) READ_STROBE_N <= 1'b0;
      else WRITE_STROBE_N <= 1'b0;
      repeat (10) @(posedge MCLK);
      #1 q = (DATA_OE === 1'b1) ? DATA_OUT : 8'hxx;
      @(posedge MCLK);
      READ_STROBE_N <= 1'b1;
      WRITE_STROBE_N <= 1'b1;
      repeat (5) @(posedge MCLK);
      CHIP_SEL_N <= 1'b1;
      ADDR_SELECT <= 1'b1;
      DATA_IN <= ~d; // Released bus shows no stale byte
      repeat (20) @(posedge MCLK);
   endtask

   // Multiplexed address phase
   task automatic latch(input logic [7:0] a);
      @(posedge MCLK);
      ALE <= 1'b1;
      DATA_IN <= a;
      repeat (6) @(posedge MCLK);
      ALE <= 1'b0;
      repeat (4) @(posedge MCLK);
      DATA_IN <= ~a;
      repeat (4) @(posedge MCLK);
   endtask

   // One DMA byte, select kept high; bad puts the strobe first
   task automatic dma(input logic bad, input logic [7:0] d);
      @(posedge MCLK);
      DATA_IN <= d;
      if (bad) WRITE_STROBE_N <= 1'b0;
      else DMA_ACK_N <= 1'b0;
      repeat (3) @(posedge MCLK);
      if (bad) DMA_ACK_N <= 1'b0;
      else WRITE_STROBE_N <= 1'b0;
      repeat (12) @(posedge MCLK);
      WRITE_STROBE_N <= 1'b1;
      repeat (3) @(posedge MCLK);
      DMA_ACK_N <= 1'b1;
      DATA_IN <= ~d;
      repeat (3) @(posedge MCLK);
   endtask
endmodule

// *** testbench.sv ***
/* Self-checking bench for byte_host_port with queued expectations.
   Needs hostport_pkg, wr_fifo and host_bus_model. */
`timescale 1ns/100ps
module testbench;
   import hostport_pkg::*;
   logic        MCLK, RESET, DEVICE_RESET_N, DMA_ENABLE, DMA_READY, stall;
   logic        CHIP_SEL_N, READ_STROBE_N, WRITE_STROBE_N, ADDR_SELECT, ALE, DMA_ACK_N;
   logic        DATA_OE, DMA_REQ_N, REG_WR, REG_RD, DMA_VALID, PORT_READY;
   logic [7:0]  DATA_IN, DATA_OUT, PTR, REG_WDATA, REG_RDATA, DMA_DATA, p, d, q;
   logic [15:0] rnd = 16'h3e94;
   logic [15:0] wq[$];
   logic [7:0]  dq[$];
   int          n_mismatch = 0, n_compared = 0, cyc = 0, i, w;

   byte_host_port dut (.*);
   host_bus_model host (.*);

   initial begin
      MCLK = 1'b0;
      forever #2.5 MCLK = ~MCLK;
   end

   ////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic chk16(input logic [15:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk8(input logic [7:0] got, exp);
      chk16({8'h00, got}, {8'h00, exp});
   endtask

   task automatic conclude;
      $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // Scoreboards, read data source, random drain stall, timeout
   always @(posedge MCLK) begin
      if (!RESET && REG_WR) chk16({PTR, REG_WDATA}, wq.size() > 0 ? wq.pop_front() : 16'hxxxx);
      if (!RESET && DMA_VALID && DMA_READY) chk8(DMA_DATA, dq.size() > 0 ? dq.pop_front() : 8'hxx);
      REG_RDATA <= PTR ^ 8'h5a;
      DMA_READY <= !stall && rnd[3];
      rnd <= lfsr(rnd);
      cyc <= cyc + 1;
      if (cyc > 10000) begin
         n_mismatch++;
         conclude();
      end
   end

   ////////////////////////////////////////////////////////////
   initial begin
      {RESET, DEVICE_RESET_N, DMA_ENABLE, stall} = 4'hd;
      repeat (5) @(posedge MCLK);
      RESET <= 1'b0;
      // No strobes until start-up is over
      for (i = 0; i < 200 && PORT_READY !== 1'b1; i++) @(posedge MCLK);
      chk8({7'h00, PORT_READY}, 8'h01);
      // Pointer, two data writes, read back
      for (int k = 0; k < 3; k++) begin
         p = rnd[15:8];
         d = rnd[7:0];
         host.acc(0, 0, 0, p, q);
         chk8(PTR, p);
         wq.push_back({p, d});
         wq.push_back({p, ~d});
         host.acc(0, 0, 1, d, q);
         host.acc(0, 0, 1, ~d, q);
         host.acc(0, 1, 1, ~p, q);
         chk8(q, p ^ 8'h5a);
      end
      // Pointer and data writes without chip select are ignored
      host.acc(1, 0, 0, ~p, q);
      host.acc(1, 0, 1, p, q);
      chk8(PTR, p);
      // Multiplexed address at both extremes
      for (i = 0; i < 2; i++) begin
         p = i ? 8'hff : 8'h00;
         d = rnd[7:0];
         host.latch(p);
         chk8(PTR, p);
         wq.push_back({p, d});
         host.acc(0, 0, 1, d, q);
      end
      // DMA: fill while stalled, then drain randomly; last byte misordered
      DMA_ENABLE <= 1'b1;
      for (i = 0; i < 21; i++) begin
         if (i == 8) begin
            repeat (30) @(posedge MCLK);
            chk8({7'h00, DMA_REQ_N}, 8'h01);
            stall = 1'b0;
         end
         for (w = 0; w < 60 && DMA_REQ_N !== 1'b0; w++) @(posedge MCLK);
         chk8({7'h00, DMA_REQ_N}, 8'h00);
         dq.push_back(rnd[7:0]);
         host.dma(i == 20, rnd[7:0]);
      end
      repeat (20) @(posedge MCLK);
      chk8({7'h00, DMA_REQ_N}, 8'h00);
      DMA_ENABLE <= 1'b0;
      repeat (5) @(posedge MCLK);
      chk8({7'h00, DMA_REQ_N}, 8'h01);
      repeat (60) @(posedge MCLK);
      // Only the misordered byte stays unmatched
      chk8(8'(dq.size()), 8'h01);
      chk8(8'(wq.size()), 8'h00);
      // Pin reset mid-run: pointer and ready go back to rest, start-up is counted again
      DEVICE_RESET_N <= 1'b0;
      repeat (70) @(posedge MCLK);
      chk8(PTR, PTR_RESET);
      chk8({7'h00, PORT_READY}, 8'h00);
      DEVICE_RESET_N <= 1'b1;
      for (i = 0; i < 200 && PORT_READY !== 1'b1; i++) @(posedge MCLK);
      chk8({7'h00, i > STARTUP_CYC && i <= STARTUP_CYC + 5}, 8'h01);
      conclude();
   end
endmodule
